// ===== design/swbp_writeback.sv
`timescale 1ns/100ps
`default_nettype none
`include "swbp_cfg.svh"
module swbp_writeback
  import swbp_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // instruction strobe and kind
  input wire logic i_valid,
  input wire swbp_pkg::swbp_kind_t i_kind,
  input wire logic i_program_end,
  input wire logic i_scatter_mode,
  // mask fields
  input wire logic [2:0] i_color_temp_write_mask,
  input wire logic i_scalar_temp_write_mask,
  input wire logic [2:0] i_color_output_mask,
  input wire logic i_scalar_output_mask,
  input wire logic i_w_channel_output_mask,
  input wire logic i_write_ignore_activity,
  input wire logic i_ignore_uncovered,
  input wire logic i_result_flag_write_enable,
  input wire logic i_result_flag_value,
  // predicate fields
  input wire swbp_pkg::swbp_psel_t i_color_predicate_select,
  input wire logic i_color_predicate_invert,
  input wire swbp_pkg::swbp_psel_t i_scalar_predicate_select,
  input wire logic i_scalar_predicate_invert,
  // targets
  input wire swbp_pkg::swbp_tgt_t i_color_target,
  input wire swbp_pkg::swbp_tgt_t i_scalar_target,
  // destination address
  input wire logic [ADDR_W-1:0] i_dest_addr,
  input wire logic i_loop_add,
  input wire logic [ADDR_W-1:0] i_loop_index_offset,
  // processor state
  input wire logic i_proc_active,
  input wire logic i_proc_covered,
  // results: r g b a, clamp/omod already applied upstream
  input wire swbp_pkg::swbp_word_t i_res_r,
  input wire swbp_pkg::swbp_word_t i_res_g,
  input wire swbp_pkg::swbp_word_t i_res_b,
  input wire swbp_pkg::swbp_word_t i_res_a,
  // temp register write
  output logic o_temp_we,
  output logic [3:0] o_temp_chan,
  output logic [ADDR_W-1:0] o_temp_addr,
  output swbp_pkg::swbp_word_t o_temp_r,
  output swbp_pkg::swbp_word_t o_temp_g,
  output swbp_pkg::swbp_word_t o_temp_b,
  output swbp_pkg::swbp_word_t o_temp_a,
  // predicate and result flag state
  output logic [3:0] o_pred,
  output logic o_result_flag,
  // flow and texture participation
  output logic o_flow_take,
  output logic o_tex_participate,
  // cached render target emit, one word per pulse
  output logic o_rt_emit,
  output logic [1:0] o_rt_index,
  output logic [4:0] o_rt_chan,
  output swbp_pkg::swbp_word_t o_rt_word,
  // scatter write
  output logic o_sc_valid,
  output logic o_sc_per_proc,
  output logic o_sc_sem_acquire,
  output swbp_pkg::swbp_word_t o_sc_value,
  output swbp_pkg::swbp_word_t o_sc_x,
  output swbp_pkg::swbp_word_t o_sc_y
);
  import swbp_pkg::*;

  // reset synchroniser
  logic rst_s1, rst_s2;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst_n = rst_s2;

  function automatic logic cond_hit(input swbp_word_t v,
                                    input swbp_tgt_t code);
    logic is_zero;
    logic neg;
    is_zero = (v[`SWBP_EXP_HI:`SWBP_EXP_LO] == 8'h00);
    neg = v[`SWBP_SIGN_BIT] && !is_zero;
    case (code)
      `SWBP_COND_ZERO: cond_hit = is_zero;
      `SWBP_COND_NEG: cond_hit = neg;
      `SWBP_COND_NONNEG: cond_hit = !neg;
      `SWBP_COND_NONZERO: cond_hit = !is_zero;
      default: cond_hit = 1'b0;
    endcase
  endfunction

  logic [3:0] pred;
  logic [3:0] color_gate, scalar_gate;

  swbp_pred_gate u_color_gate (
    .i_pred(pred),
    .i_sel(i_color_predicate_select),
    .i_inv(i_color_predicate_invert),
    .o_gate(color_gate)
  );
  swbp_pred_gate u_scalar_gate (
    .i_pred(pred),
    .i_sel(i_scalar_predicate_select),
    .i_inv(i_scalar_predicate_invert),
    .o_gate(scalar_gate)
  );

  // instruction kind decode
  wire is_alu = i_valid && (i_kind == `SWBP_KIND_ALU);
  wire is_out = i_valid && (i_kind == `SWBP_KIND_OUT);
  wire is_tex = i_valid && (i_kind == `SWBP_KIND_TEX);
  wire is_flow = i_valid && (i_kind == `SWBP_KIND_FLOW);

  // activity qualification for alu, output and texture writes
  wire may_write = i_write_ignore_activity || i_proc_active;
  // coverage qualification for texture and flow
  wire covered_ok = !i_ignore_uncovered || i_proc_covered;

  // texture also goes through the unit gates
  wire tex_ok = !is_tex || covered_ok;
  wire temp_kind = is_alu || is_tex || is_out;
  // per-channel temp mask, gated by old predicate
  wire [3:0] temp_mask = {i_scalar_temp_write_mask, i_color_temp_write_mask};
  // old predicate gates the temp mask, as it does the output masks and flow
  wire [3:0] next_temp_chan = temp_mask &
    {scalar_gate[3], color_gate[2:0]};
  wire next_temp_we = temp_kind && may_write && tex_ok &&
    (next_temp_chan != 4'h0);
  wire [ADDR_W-1:0] next_temp_addr = i_loop_add ?
    ADDR_W'(i_dest_addr + i_loop_index_offset) : i_dest_addr;

  // alu output mask is the predicate write mask
  wire [3:0] pwmask = {i_scalar_output_mask, i_color_output_mask};
  wire [3:0] pcond = {cond_hit(i_res_a, i_scalar_target),
                      cond_hit(i_res_b, i_color_target),
                      cond_hit(i_res_g, i_color_target),
                      cond_hit(i_res_r, i_color_target)};
  wire pred_upd = is_alu && may_write;
  wire [3:0] next_pred = pred_upd ?
    ((pred & ~pwmask) | (pcond & pwmask)) : pred;

  // flow decision uses colour predicate only
  wire next_flow_take = is_flow && covered_ok && (color_gate[0]);

  // output masks gated by unit predicates
  wire [2:0] out_c = i_color_output_mask & color_gate[2:0];
  wire out_a = i_scalar_output_mask & scalar_gate[3];
  wire out_w = i_w_channel_output_mask & scalar_gate[3];
  wire out_ok = is_out && may_write;

  wire sc_tgt = i_color_target[2];
  wire sc_all = (out_c == 3'h7) && out_a;
  wire next_sc_valid = out_ok && i_scatter_mode && sc_tgt && sc_all;

  // render target storage: 4 targets x r,g,b,a,w
  swbp_word_t rt_mem [0:19];
  logic emitting;
  logic [4:0] emit_idx;
  wire [1:0] rt_c = i_color_target[1:0];
  wire [1:0] rt_a = i_scalar_target[1:0];
  // cached writes pick a render target per unit
  wire cache_wr = out_ok && !i_scatter_mode;
  wire [4:0] base_c = 5'(rt_c * 5);
  wire [4:0] base_a = 5'(rt_a * 5);

  always_ff @(posedge i_core_clk) begin
    if (cache_wr) begin
      if (out_c[0]) rt_mem[base_c] <= i_res_r;
      if (out_c[1]) rt_mem[5'(base_c + 5'h01)] <= i_res_g;
      if (out_c[2]) rt_mem[5'(base_c + 5'h02)] <= i_res_b;
      if (out_a) rt_mem[5'(base_a + 5'h03)] <= i_res_a;
      if (out_w) rt_mem[5'(base_a + 5'h04)] <= i_res_a;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      emitting <= 1'b0;
      emit_idx <= 5'h00;
    end else if (!emitting && i_program_end && !i_scatter_mode) begin
      emitting <= 1'b1;
      emit_idx <= 5'h00;
    end else if (emitting) begin
      // wrap to slot zero so idle reads stay inside the store
      emit_idx <= (emit_idx == `SWBP_RT_LAST) ? 5'h00 :
        5'(emit_idx + 5'h01);
      if (emit_idx == `SWBP_RT_LAST) emitting <= 1'b0;
    end
  end

  // predicate and flag state
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pred <= `SWBP_PRED_RST;
      o_result_flag <= 1'b0;
    end else begin
      pred <= next_pred;
      if (is_alu && may_write && i_result_flag_write_enable)
        o_result_flag <= i_result_flag_value;
    end
  end
  assign o_pred = pred;

  // registered write-back outputs
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_temp_we <= 1'b0;
      o_temp_chan <= 4'h0;
      o_temp_addr <= '0;
      o_temp_r <= `SWBP_DW_RST;
      o_temp_g <= `SWBP_DW_RST;
      o_temp_b <= `SWBP_DW_RST;
      o_temp_a <= `SWBP_DW_RST;
      o_flow_take <= 1'b0;
      o_tex_participate <= 1'b0;
    end else begin
      o_temp_we <= next_temp_we;
      o_temp_chan <= next_temp_we ? next_temp_chan : 4'h0;
      o_temp_addr <= next_temp_addr;
      o_temp_r <= i_res_r;
      o_temp_g <= i_res_g;
      o_temp_b <= i_res_b;
      o_temp_a <= i_res_a;
      o_flow_take <= next_flow_take;
      o_tex_participate <= is_tex && covered_ok;
    end
  end

  // render target emit outputs
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rt_emit <= 1'b0;
      o_rt_index <= 2'h0;
      o_rt_chan <= 5'h00;
      o_rt_word <= `SWBP_DW_RST;
    end else begin
      o_rt_emit <= emitting;
      o_rt_index <= 2'(emit_idx / 5);
      o_rt_chan <= emit_idx;
      o_rt_word <= rt_mem[emit_idx];
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sc_valid <= 1'b0;
      o_sc_per_proc <= 1'b0;
      o_sc_sem_acquire <= 1'b0;
      o_sc_value <= `SWBP_DW_RST;
      o_sc_x <= `SWBP_DW_RST;
      o_sc_y <= `SWBP_DW_RST;
    end else begin
      o_sc_valid <= next_sc_valid;
      o_sc_per_proc <= i_color_target[1];
      o_sc_sem_acquire <= i_color_target[0];
      o_sc_value <= i_res_r;
      o_sc_x <= i_res_g;
      o_sc_y <= i_res_b;
    end
  end

  a_pred_write_mask: assert property (@(posedge i_core_clk)
    disable iff (!rst_n) (is_alu && may_write && pwmask == 4'hF) |=>
    (pred == $past(pcond))) else $error("predicate mask gated");

  a_flag_hold: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !(is_alu && i_result_flag_write_enable) |=>
    $stable(o_result_flag)) else $error("result flag changed");

  a_inactive_nowr: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    (!i_proc_active && !i_write_ignore_activity) |=> !o_temp_we)
    else $error("inactive processor wrote");

  a_temp_subset: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    1'b1 |=> ((o_temp_chan & ~$past(temp_mask)) == 4'h0))
    else $error("unmasked channel written");

  a_sc_all: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (is_out && i_scatter_mode && !sc_all) |=> !o_sc_valid)
    else $error("partial scatter emitted");

  a_sc_mode: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !i_scatter_mode |=> !o_sc_valid)
    else $error("scatter in cached mode");

  a_emit_len: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    $rose(emitting) |-> emitting [*8] ##12 emitting ##1 !emitting)
    else $error("emit length wrong");

  a_loop_addr: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    i_loop_add |=> o_temp_addr ==
    ADDR_W'($past(i_dest_addr) + $past(i_loop_index_offset)))
    else $error("loop offset missing");
endmodule
`default_nettype wire

// ===== include/swbp_cfg.svh
`ifndef SWBP_CFG_SVH
`define SWBP_CFG_SVH
// predicate select codes
`define SWBP_PSEL_NONE 3'h0
`define SWBP_PSEL_RGBA 3'h1
`define SWBP_PSEL_RRRR 3'h2
`define SWBP_PSEL_GGGG 3'h3
`define SWBP_PSEL_BBBB 3'h4
`define SWBP_PSEL_AAAA 3'h5
// instruction kind codes
`define SWBP_KIND_ALU 2'h0
`define SWBP_KIND_OUT 2'h1
`define SWBP_KIND_TEX 2'h2
`define SWBP_KIND_FLOW 2'h3
// alu target: predicate condition codes
`define SWBP_COND_ZERO 3'h0
`define SWBP_COND_NEG 3'h1
`define SWBP_COND_NONNEG 3'h2
`define SWBP_COND_NONZERO 3'h3
// output target codes
`define SWBP_TGT_RT_A 3'h0
`define SWBP_TGT_RT_B 3'h1
`define SWBP_TGT_RT_C 3'h2
`define SWBP_TGT_RT_D 3'h3
`define SWBP_TGT_SC_SHARED 3'h4
`define SWBP_TGT_SC_SHARED_SEM 3'h5
`define SWBP_TGT_SC_PERPROC 3'h6
`define SWBP_TGT_SC_PERPROC_SEM 3'h7
// float fields
`define SWBP_SIGN_BIT 31
`define SWBP_EXP_HI 30
`define SWBP_EXP_LO 23
// reset values
`define SWBP_PRED_RST 4'h0
`define SWBP_DW_RST 32'h0000_0000
// last render target slot of the emit walk
`define SWBP_RT_LAST 5'h13
`endif

// ===== include/swbp_pkg.sv
package swbp_pkg;
  typedef logic [31:0] swbp_word_t;
  typedef logic [2:0] swbp_psel_t;
  typedef logic [1:0] swbp_kind_t;
  typedef logic [2:0] swbp_tgt_t;
endpackage

// ===== design/swbp_pred_gate.sv
`timescale 1ns/100ps
`default_nettype none
`include "swbp_cfg.svh"
// turns a predicate select and invert into a 4-bit channel gate
module swbp_pred_gate
  import swbp_pkg::*;
(
  // predicate state
  input wire logic [3:0] i_pred,
  // select fields
  input wire swbp_pkg::swbp_psel_t i_sel,
  input wire logic i_inv,
  // resulting gate, bit 3 is alpha
  output logic [3:0] o_gate
);
  import swbp_pkg::*;
  logic [3:0] raw;
  // pick predicate bits per mode
  assign raw = (i_sel == `SWBP_PSEL_RGBA) ? i_pred :
               (i_sel == `SWBP_PSEL_RRRR) ? {4{i_pred[0]}} :
               (i_sel == `SWBP_PSEL_GGGG) ? {4{i_pred[1]}} :
               (i_sel == `SWBP_PSEL_BBBB) ? {4{i_pred[2]}} :
               (i_sel == `SWBP_PSEL_AAAA) ? {4{i_pred[3]}} : 4'hF;
  assign o_gate = (i_sel == `SWBP_PSEL_NONE) ? 4'hF :
                  (i_inv ? ~raw : raw);
endmodule
`default_nettype wire

// ===== test/swbp_rt_sink.sv
`timescale 1ns/100ps
`default_nettype none
// far-side render target sink, one slot per emitted word
module swbp_rt_sink
  import swbp_pkg::*;
(
  // clock and count clear
  input wire logic i_core_clk,
  input wire logic i_clear,
  // emit stream
  input wire logic i_rt_emit,
  input wire logic [4:0] i_rt_chan,
  input wire swbp_pkg::swbp_word_t i_rt_word,
  // captured words
  output swbp_pkg::swbp_word_t o_mem [20],
  output int o_count
);
  import swbp_pkg::*;
  always @(posedge i_core_clk) begin
    if (i_clear) begin
      o_count <= 0;
    end else if (i_rt_emit) begin
      o_mem[i_rt_chan] <= i_rt_word;
      o_count <= o_count + 1;
    end
  end
endmodule
`default_nettype wire

// ===== test/shader_writeback_predication_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "swbp_cfg.svh"
// self-checking bench for the write-back stage
module shader_writeback_predication_tb;
  import swbp_pkg::*;
`define CHK(a, b, m) begin \
    checked++; \
    if ((a) !== (b)) begin \
      fail_count++; \
      $display("[ERR] %0t %s", $time, m); \
    end \
  end
  logic clk = 1'b0, rst_b = 1'b0, scm = 1'b0, valid, pend;
  swbp_kind_t kind;
  logic [2:0] cwm, com;
  logic swm, som, wom, wia, iu, rfwe, rfv, cinv, sinv, ladd, act, cov;
  swbp_psel_t csel, ssel;
  swbp_tgt_t ctgt, stgt;
  logic [6:0] dst, loff, taddr;
  swbp_word_t rr, rg, rb, ra, tr, tgv, tbv, tav, rtw, scval, scx, scy;
  logic [1:0] rtidx;
  logic twe, rflag, ftake, tpart, rte, scv, scpp, scsem;
  logic [3:0] tchan, pred, ep = 4'h0, sp;
  logic [4:0] rtch;
  logic efl = 1'b0, ef, et, sfl, sf, st;
  logic [138:0] tq [$];
  logic [97:0] sq [$];
  logic [138:0] n;
  logic [97:0] s;
  swbp_word_t er [20];
  swbp_word_t mem [20];
  int scnt, seed, checked = 0, fail_count = 0;

  always #5 clk = ~clk;

  swbp_writeback uut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_valid(valid), .i_kind(kind),
    .i_program_end(pend), .i_scatter_mode(scm),
    .i_color_temp_write_mask(cwm), .i_scalar_temp_write_mask(swm),
    .i_color_output_mask(com), .i_scalar_output_mask(som),
    .i_w_channel_output_mask(wom), .i_write_ignore_activity(wia),
    .i_ignore_uncovered(iu), .i_result_flag_write_enable(rfwe),
    .i_result_flag_value(rfv), .i_color_predicate_select(csel),
    .i_color_predicate_invert(cinv), .i_scalar_predicate_select(ssel),
    .i_scalar_predicate_invert(sinv), .i_color_target(ctgt),
    .i_scalar_target(stgt), .i_dest_addr(dst), .i_loop_add(ladd),
    .i_loop_index_offset(loff), .i_proc_active(act), .i_proc_covered(cov),
    .i_res_r(rr), .i_res_g(rg), .i_res_b(rb), .i_res_a(ra),
    .o_temp_we(twe), .o_temp_chan(tchan), .o_temp_addr(taddr),
    .o_temp_r(tr), .o_temp_g(tgv), .o_temp_b(tbv), .o_temp_a(tav),
    .o_pred(pred),
    .o_result_flag(rflag), .o_flow_take(ftake), .o_tex_participate(tpart),
    .o_rt_emit(rte), .o_rt_index(rtidx), .o_rt_chan(rtch), .o_rt_word(rtw),
    .o_sc_valid(scv), .o_sc_per_proc(scpp), .o_sc_sem_acquire(scsem),
    .o_sc_value(scval), .o_sc_x(scx), .o_sc_y(scy)
  );

  swbp_rt_sink sink (
    .i_core_clk(clk), .i_clear(pend), .i_rt_emit(rte), .i_rt_chan(rtch),
    .i_rt_word(rtw), .o_mem(mem), .o_count(scnt)
  );

  // channel gate from predicate, select and invert
  function automatic logic [3:0] gate(logic [3:0] p, logic [2:0] c, logic v);
    case (c)
      `SWBP_PSEL_RGBA: gate = p ^ {4{v}};
      `SWBP_PSEL_RRRR: gate = {4{p[0] ^ v}};
      `SWBP_PSEL_GGGG: gate = {4{p[1] ^ v}};
      `SWBP_PSEL_BBBB: gate = {4{p[2] ^ v}};
      `SWBP_PSEL_AAAA: gate = {4{p[3] ^ v}};
      default: gate = 4'hF;
    endcase
  endfunction

  // predicate condition, zero exponent counts as zero
  function automatic logic cnd(logic [31:0] w, logic [2:0] c);
    logic z;
    z = (w[30:23] == 8'h00);
    case (c)
      `SWBP_COND_ZERO: cnd = z;
      `SWBP_COND_NEG: cnd = w[31] & !z;
      `SWBP_COND_NONNEG: cnd = !(w[31] & !z);
      default: cnd = !z;
    endcase
  endfunction

  // quiet every input except scatter mode, with active and covered held high
  task automatic blank();
    {valid, kind, pend, cwm, swm, com, som, wom, wia, iu, rfwe, rfv} = '0;
    {csel, cinv, ssel, sinv, ctgt, stgt, dst, ladd, loff, ef, et} = '0;
    {act, cov} = 2'h3;
    {rr, rg, rb, ra} = '0;
  endtask

  // present the instruction on the inputs and note its results
  task automatic issue();
    logic [3:0] gc, gs, ch;
    logic a, ok;
    gc = gate(ep, csel, cinv);
    gs = gate(ep, ssel, sinv);
    a = act | wia;
    ok = cov | !iu;
    ch = {swm & gs[3], cwm & gc[2:0]};
    valid = 1'b1;
    ef = (kind == `SWBP_KIND_FLOW) & ok & gc[0];
    et = (kind == `SWBP_KIND_TEX) & ok;
    if (kind == `SWBP_KIND_FLOW || !a || (kind == `SWBP_KIND_TEX && !ok))
      ch = 4'h0;
    if (ch != 4'h0)
      tq.push_back({ch, dst + (ladd ? loff : 7'h00), rr, rg, rb, ra});
    if (kind == `SWBP_KIND_ALU && a) begin
      for (int i = 0; i < 3; i++)
        if (com[i]) ep[i] = cnd(i == 0 ? rr : (i == 1 ? rg : rb), ctgt);
      if (som) ep[3] = cnd(ra, stgt);
      if (rfwe) efl = rfv;
    end
    if (scm && kind == `SWBP_KIND_OUT && com == 3'h7 && som)
      sq.push_back({ctgt[1], ctgt[0], rr, rg, rb});
  endtask

  task automatic done(string nm);
    $display("test %s done", nm);
  endtask

  task automatic conclude();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // what the stage should show after the taking edge
  always @(posedge clk) begin
    sp <= ep;
    sfl <= efl;
    sf <= valid & ef;
    st <= valid & et;
  end

  // output watcher, takes the oldest note per result
  always @(negedge clk) begin
    if (rst_b) begin
      `CHK(pred, sp, "predicate bits")
      `CHK(rflag, sfl, "result flag")
      `CHK({ftake, tpart}, {sf, st}, "flow or texture")
      if (twe && tchan !== 4'h0) begin
        n = tq.size() ? tq.pop_front() : 'x;
        `CHK({tchan, taddr, tr, tgv, tbv, tav}, n, "temp write")
      end
      if (rte)
        `CHK(rtidx, 2'(rtch / 5), "render index")
      if (scv) begin
        s = sq.size() ? sq.pop_front() : 'x;
        `CHK({scpp, scsem, scval, scx, scy}, s, "scatter")
      end
    end
  end

  initial begin
    #200000;
    fail_count++;
    $display("[ERR] %0t run timeout", $time);
    conclude();
  end

  initial begin
    seed = 38;
    blank();
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    // random back-to-back instructions, cached mode
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      #1;
      {cwm, swm, com, som, wom, wia, iu, rfv, cinv, sinv, ladd, act, cov} =
        17'($random(seed));
      kind = 2'($random(seed));
      csel = 3'({$random(seed)} % 6);
      ssel = 3'({$random(seed)} % 6);
      ctgt = 3'({$random(seed)} % 4);
      stgt = 3'({$random(seed)} % 4);
      {dst, loff} = 14'($random(seed));
      {rr, rg, rb, ra} = {$random(seed), $random(seed), $random(seed),
        $random(seed)};
      if (rr[0]) {rr[30:23], rb[30:23]} = 16'h0000;
      if (rg[0]) {rg[30:23], ra[30:23]} = 16'h0000;
      if (csel == `SWBP_PSEL_NONE) cinv = 1'b0;
      if (ssel == `SWBP_PSEL_NONE) sinv = 1'b0;
      if (kind == `SWBP_KIND_TEX || kind == `SWBP_KIND_FLOW) act = 1'b1;
      rfwe = (kind == `SWBP_KIND_ALU) & $random(seed);
      issue();
    end
    done("random");
    // whole scatter program, every code, last one partial
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      #1;
      blank();
      scm = 1'b1;
      kind = `SWBP_KIND_OUT;
      ctgt = 3'h4 + 3'(k % 4);
      stgt = 3'(k); // alpha target plays no part
      com = (k == 4) ? 3'h3 : 3'h7;
      som = 1'b1;
      {rr, rg, rb} = {$random(seed), $random(seed), $random(seed)};
      issue();
    end
    @(posedge clk);
    #1;
    blank();
    scm = 1'b0;
    done("scatter");
    // two passes over all targets, last write wins
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1;
      blank();
      kind = `SWBP_KIND_OUT;
      {com, som, wom} = 5'h1F;
      ctgt = 3'(k % 4);
      stgt = 3'(3 - k % 4);
      {rr, rg, rb, ra} = {$random(seed), $random(seed), $random(seed),
        $random(seed)};
      {er[ctgt * 5], er[ctgt * 5 + 1], er[ctgt * 5 + 2]} = {rr, rg, rb};
      {er[stgt * 5 + 3], er[stgt * 5 + 4]} = {ra, ra};
      issue();
    end
    @(posedge clk);
    #1;
    blank();
    pend = 1'b1;
    @(posedge clk);
    #1;
    pend = 1'b0;
    for (int c = 0; c < 40 && scnt != 20; c++) @(posedge clk);
    repeat (3) @(posedge clk);
    `CHK(scnt, 20, "emit count")
    if (scnt != 20) conclude();
    for (int k = 0; k < 20; k++)
      `CHK(mem[k], er[k], "render word")
    `CHK(tq.size() + sq.size(), 0, "missing results")
    done("render targets");
    conclude();
  end
endmodule
`default_nettype wire
